/* wlsm_pkg.sv */
/*
 * shared constants and types for the weld limit stop monitor: register
 * offsets, field positions, reset values, error codes, modes and states.
 * assumes a 32-bit apb register bus with byte addresses.
 */
`default_nettype none

package wlsm_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;   // mode and run threshold
    localparam logic [7:0] OFF_CUR_LIM = 8'h04;   // current lower / upper limit
    localparam logic [7:0] OFF_ANG_LIM = 8'h08;   // angle lower / upper limit
    localparam logic [7:0] OFF_STATUS = 8'h0c;   // live state, read only
    localparam logic [7:0] OFF_ACK = 8'h10;   // halt acknowledge, write only
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;   // sticky events, read only
    localparam logic [7:0] OFF_IRQ_CLR = 8'h18;   // write one to clear
    localparam logic [7:0] OFF_IRQ_EN = 8'h1c;   // interrupt enables
    localparam logic [7:0] OFF_LAST_CODE = 8'h20;   // code of last weld

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_THR_LSB = 4;
    localparam int LIM_LO_LSB = 0;
    localparam int CUR_HI_LSB = 16;
    localparam int ANG_HI_LSB = 8;
    localparam int STAT_HALT_BIT = 0;
    localparam int STAT_WAIT_BIT = 1;
    localparam int STAT_RUN_LSB = 4;
    localparam int STAT_CODE_LSB = 16;
    localparam int ACK_BIT = 0;
    localparam int IRQ_BAD_BIT = 0;
    localparam int IRQ_HALT_BIT = 1;
    localparam int IRQ_REFUSE_BIT = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] CUR_LO_RST = 16'h0000;
    localparam logic [15:0] CUR_HI_RST = 16'hffff;
    localparam logic [7:0] ANG_LO_RST = 8'h00;
    localparam logic [7:0] ANG_HI_RST = 8'hff;

    // ------------------------------------------------------------------
    // error codes, zero means none
    // ------------------------------------------------------------------
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_LOW_CURRENT = 16'h0106;
    localparam logic [15:0] CODE_HIGH_CURRENT = 16'h0107;
    localparam logic [15:0] CODE_LOW_ANGLE = 16'h0108;
    localparam logic [15:0] CODE_HIGH_ANGLE = 16'h0109;

    // limit check mode of the active program
    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_CURRENT_CHECK = 2'h1,
        MODE_ANGLE_CHECK = 2'h2,
        MODE_COMBINED = 2'h3
    } wlsm_mode_t;

    // cycle gate states, one-hot
    typedef enum logic [2:0] {
        ST_WAIT_RELEASE = 3'b001,
        ST_READY = 3'b010,
        ST_HALTED = 3'b100
    } wlsm_state_t;

    // one finished weld's measurements
    typedef struct packed {
        logic [15:0] current;
        logic [7:0] angle;
    } wlsm_meas_t;

endpackage : wlsm_pkg

`default_nettype wire

/* wlsm_monitor.sv */
/*
 * weld limit stop monitor: classifies each weld finished in the ready state against the
 * programmed limits, counts unbroken runs of bad welds, halts the welder
 * with an error code at the threshold and gates the cycle-start line.
 * assumes one clock pclk, apb register access, and weld_done pulses of
 * one cycle with the measurement valid in the same cycle.
 */
`default_nettype none

module wlsm_monitor #(
    parameter int THR_W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wlsm_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic weld_done,
    input wire wlsm_pkg::wlsm_meas_t weld_meas,
    input wire logic cycle_start,
    output logic cycle_go,
    output logic halt,
    output logic [15:0] error_code,
    output logic irq
);
    import wlsm_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (THR_W < 1 || THR_W > 4) begin : g_thr_check
        $error("THR_W must lie between 1 and 4");
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    wlsm_mode_t mode_q;                 // limit check mode
    logic [THR_W-1:0] thr_q;            // run length that halts
    logic [15:0] current_lower_limit_q;
    logic [15:0] current_upper_limit_q;
    logic [7:0] angle_lower_limit_q;
    logic [7:0] angle_upper_limit_q;
    wlsm_state_t state_q, state_d;      // cycle gate
    logic [THR_W-1:0] run_q, run_d;     // consecutive bad welds
    logic [15:0] last_code_q;           // code of most recent weld
    logic [15:0] halt_code_q;           // code frozen at halt
    logic [IRQ_W-1:0] irq_stat_q;       // sticky events
    logic [IRQ_W-1:0] irq_en_q;         // event enables
    logic [31:0] prdata_q;              // read data captured in setup

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en = access_ph & pwrite;
    wire hit_ctrl = (paddr == OFF_CTRL);
    wire hit_cur = (paddr == OFF_CUR_LIM);
    wire hit_ang = (paddr == OFF_ANG_LIM);
    wire hit_stat = (paddr == OFF_STATUS);
    wire hit_ack = (paddr == OFF_ACK);
    wire hit_istat = (paddr == OFF_IRQ_STAT);
    wire hit_iclr = (paddr == OFF_IRQ_CLR);
    wire hit_ien = (paddr == OFF_IRQ_EN);
    wire hit_last = (paddr == OFF_LAST_CODE);
    wire addr_ok = hit_ctrl | hit_cur | hit_ang | hit_stat | hit_ack
                 | hit_istat | hit_iclr | hit_ien | hit_last;
    wire ack_wr = wr_en & hit_ack & pwdata[ACK_BIT];
    wire [IRQ_W-1:0] iclr = (wr_en & hit_iclr) ? pwdata[IRQ_W-1:0] : '0;

    // single-cycle access: setup captures data, access completes
    assign pready = 1'b1;
    assign pslverr = access_ph & ~addr_ok;
    assign prdata = prdata_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [31:0] rd_ctrl = {24'h000000, 4'(thr_q), 2'h0, mode_q};
    wire [31:0] rd_cur = {current_upper_limit_q, current_lower_limit_q};
    wire [31:0] rd_ang = {16'h0000, angle_upper_limit_q, angle_lower_limit_q};
    wire [31:0] rd_stat = {error_code, 8'h00, 4'(run_q), 2'h0,
                           (state_q == ST_WAIT_RELEASE), halt};
    wire [31:0] rd_istat = {29'h00000000, irq_stat_q};
    wire [31:0] rd_ien = {29'h00000000, irq_en_q};
    wire [31:0] rd_last = {16'h0000, last_code_q};
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                         hit_cur ? rd_cur :
                         hit_ang ? rd_ang :
                         hit_stat ? rd_stat :
                         hit_istat ? rd_istat :
                         hit_ien ? rd_ien :
                         hit_last ? rd_last : 32'h0000_0000;

    // ------------------------------------------------------------------
    // limit classification of the finished weld
    // ------------------------------------------------------------------
    wire cur_en = (mode_q == MODE_CURRENT_CHECK) | (mode_q == MODE_COMBINED);
    wire ang_en = (mode_q == MODE_ANGLE_CHECK) | (mode_q == MODE_COMBINED);
    wire cur_low = cur_en & (weld_meas.current < current_lower_limit_q);
    wire cur_high = cur_en & (weld_meas.current > current_upper_limit_q);
    wire ang_low = ang_en & (weld_meas.angle < angle_lower_limit_q);
    wire ang_high = ang_en & (weld_meas.angle > angle_upper_limit_q);
    wire weld_bad = cur_low | cur_high | ang_low | ang_high;
    // current faults named first when both kinds occur
    wire [15:0] weld_code = cur_low ? CODE_LOW_CURRENT :
                            cur_high ? CODE_HIGH_CURRENT :
                            ang_low ? CODE_LOW_ANGLE :
                            ang_high ? CODE_HIGH_ANGLE : CODE_NONE;
    wire weld_eval = weld_done & (state_q == ST_READY);
    wire [THR_W-1:0] run_inc = (run_q == {THR_W{1'b1}}) ? run_q
                              : run_q + THR_W'(1);
    wire halt_hit = weld_eval & weld_bad & (thr_q != '0) & (run_inc >= thr_q);

    // ------------------------------------------------------------------
    // run counter next value
    // ------------------------------------------------------------------
    always_comb begin
        run_d = run_q;
        if (ack_wr) begin
            run_d = '0;
        end else if (weld_eval) begin
            run_d = weld_bad ? run_inc : '0;
        end
    end

    // ------------------------------------------------------------------
    // cycle gate state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_WAIT_RELEASE: begin
                if (!cycle_start) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                if (halt_hit) begin
                    state_d = ST_HALTED;
                end
            end
            // ack restarts, demanding a fresh press
            ST_HALTED: begin
                if (ack_wr) begin
                    state_d = ST_WAIT_RELEASE;
                end
            end
            default: begin
                state_d = ST_WAIT_RELEASE;
            end
        endcase
    end

    assign cycle_go = (state_q == ST_READY) & cycle_start & ~halt_hit;
    assign halt = (state_q == ST_HALTED);
    assign error_code = halt ? halt_code_q : CODE_NONE;

    // ------------------------------------------------------------------
    // interrupt events, set wins over clear
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    always_comb begin
        ev = '0;
        ev[IRQ_BAD_BIT] = weld_eval & weld_bad;
        ev[IRQ_HALT_BIT] = halt_hit;
        ev[IRQ_REFUSE_BIT] = (state_q == ST_WAIT_RELEASE) & cycle_start;
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_NONE;
            thr_q <= THR_W'(CTRL_RST);
            current_lower_limit_q <= CUR_LO_RST;
            current_upper_limit_q <= CUR_HI_RST;
            angle_lower_limit_q <= ANG_LO_RST;
            angle_upper_limit_q <= ANG_HI_RST;
            irq_en_q <= '0;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                mode_q <= wlsm_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
                thr_q <= pwdata[CTRL_THR_LSB +: THR_W];
            end
            if (hit_cur) begin
                current_lower_limit_q <= pwdata[LIM_LO_LSB +: 16];
                current_upper_limit_q <= pwdata[CUR_HI_LSB +: 16];
            end
            if (hit_ang) begin
                angle_lower_limit_q <= pwdata[LIM_LO_LSB +: 8];
                angle_upper_limit_q <= pwdata[ANG_HI_LSB +: 8];
            end
            if (hit_ien) begin
                irq_en_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // monitor state registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_WAIT_RELEASE;
            run_q <= '0;
            last_code_q <= CODE_NONE;
            halt_code_q <= CODE_NONE;
            irq_stat_q <= '0;
            prdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            run_q <= run_d;
            irq_stat_q <= (irq_stat_q & ~iclr) | ev;
            if (weld_eval) begin
                last_code_q <= weld_code;
            end
            if (halt_hit) begin
                halt_code_q <= weld_code;
            end
            if (setup_ph & ~pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_bad_weld;
        weld_eval && weld_bad;
    endsequence

    sequence s_halt_reached;
        s_bad_weld ##0 ((thr_q != '0) && (run_inc >= thr_q));
    endsequence

    thr_zero_a: assert property (
        (weld_eval && thr_q == '0) |=> !halt)
        else $error("halt entered with zero threshold");

    run_break_a: assert property (
        (weld_eval && !weld_bad && !ack_wr) |=> (run_q == '0) && !halt)
        else $error("good weld did not break the run");

    run_grow_a: assert property (
        (s_bad_weld and (!ack_wr && run_q < thr_q - THR_W'(1))) |=>
            (run_q == $past(run_q) + THR_W'(1)) && !halt)
        else $error("bad run did not advance by one");

    mode_off_a: assert property (
        (mode_q == MODE_NONE) |-> !weld_bad)
        else $error("weld classified bad without check mode");

    cur_code_a: assert property (
        (weld_eval && mode_q == MODE_CURRENT_CHECK &&
         weld_meas.current > current_upper_limit_q) |=>
            last_code_q == 16'h0107)
        else $error("high current code wrong");

    ang_code_a: assert property (
        (weld_eval && mode_q == MODE_ANGLE_CHECK &&
         weld_meas.angle < angle_lower_limit_q) |=> last_code_q == 16'h0108)
        else $error("low angle code wrong");

    all_mode_a: assert property (
        (weld_eval && mode_q == MODE_COMBINED &&
         weld_meas.angle > angle_upper_limit_q) |-> weld_bad)
        else $error("combined mode missed angle fault");

    halt_entry_a: assert property (
        s_halt_reached |=> halt && !cycle_go &&
            error_code == $past(weld_code) && error_code != 16'h0000)
        else $error("halt not entered with the last code");

    start_block_a: assert property (
        ($rose(presetn) && cycle_start) |-> !cycle_go ##1 !cycle_go)
        else $error("cycle passed with start held at power-up");

    ack_clear_a: assert property (
        (halt && ack_wr) |=> (run_q == '0) && !halt && error_code == 16'h0000)
        else $error("ack did not clear run and halt");

    // ------------------------------------------------------------------
    // gate, halt hold, code, run and interrupt checks
    // ------------------------------------------------------------------
    wait_gate_a: assert property (
        (state_q == ST_WAIT_RELEASE && cycle_start) |=> !cycle_go)
        else $error("cycle passed while waiting for release");

    halt_hold_a: assert property (
        (halt && !ack_wr) |=> halt && $stable(error_code))
        else $error("halt or its code changed before ack");

    none_code_a: assert property (
        (weld_eval && mode_q == MODE_NONE) |=> last_code_q == 16'h0000)
        else $error("code recorded without check mode");

    ack_run_a: assert property (
        (ack_wr && !halt) |=> run_q == '0)
        else $error("ack did not clear the run");

    irq_set_a: assert property (
        (|(ev & irq_en_q)) |=> irq)
        else $error("enabled event did not raise the interrupt");

endmodule : wlsm_monitor

`default_nettype wire

/* wlsm_weld_src.sv */
/*
 * partner model: weld measurement front end and operator start line.
 * assumes the bench calls send() from one process at a time.
 */
`default_nettype none

module wlsm_weld_src (
    input wire logic pclk,
    input wire logic op_start,
    output logic weld_done,
    output wlsm_pkg::wlsm_meas_t weld_meas,
    output logic cycle_start
);
    timeunit 1ns;
    timeprecision 1ps;
    import wlsm_pkg::*;

    // ------------------------------------------------------------------
    // operator start line
    // ------------------------------------------------------------------
    // operator level passed
    assign cycle_start = op_start;

    // idle values at time zero
    initial begin
        weld_done = 1'b0;
        weld_meas = '1;
    end

    // ------------------------------------------------------------------
    // one finished weld
    // ------------------------------------------------------------------
    // one-cycle pulse; measurement then shows its inverse, not stale data
    task automatic send(input wlsm_meas_t x);
        @(posedge pclk);
        weld_done <= 1'b1;
        weld_meas <= x;
        @(posedge pclk);
        weld_done <= 1'b0;
        weld_meas <= ~x;
    endtask : send
endmodule : wlsm_weld_src

`default_nettype wire

/* weld_limit_stop_monitor_tb.sv */
/*
 * self-checking bench for the weld limit stop monitor.
 * assumes wlsm_pkg, wlsm_monitor and the partner model wlsm_weld_src.
 */
`default_nettype none

// counts a comparison and reports a mismatch
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end

module weld_limit_stop_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wlsm_pkg::*;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, weld_done, cycle_start, cycle_go, halt, irq, er;
    logic op_start = 1'b1;  // start held at power-up
    logic [15:0] error_code, code;
    logic [15:0] cl = 16'h1000, ch = 16'h2000;  // current limits
    logic [7:0] al = 8'h40, ah = 8'hc0;  // angle limits
    wlsm_meas_t weld_meas, m;
    wlsm_meas_t bad = '{16'h0100, 8'h80}, good = '{16'h1800, 8'h80};
    int failures = 0, comparisons = 0;

    always #4 pclk = ~pclk;

    wlsm_monitor #(.THR_W(4)) i_wlsm_monitor (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .weld_done(weld_done), .weld_meas(weld_meas), .cycle_start(cycle_start),
        .cycle_go(cycle_go), .halt(halt), .error_code(error_code), .irq(irq));

    wlsm_weld_src i_wlsm_weld_src (.pclk(pclk), .op_start(op_start),
        .weld_done(weld_done), .weld_meas(weld_meas), .cycle_start(cycle_start));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // expected code, priority low/high current then low/high angle
    function automatic logic [15:0] exp_code(input logic [1:0] md, input wlsm_meas_t x);
        if (md[0] && x.current < cl) return CODE_LOW_CURRENT;
        if (md[0] && x.current > ch) return CODE_HIGH_CURRENT;
        if (md[1] && x.angle < al) return CODE_LOW_ANGLE;
        if (md[1] && x.angle > ah) return CODE_HIGH_ANGLE;
        return CODE_NONE;
    endfunction : exp_code

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // sends a weld and checks the recorded code
    task automatic weld(input wlsm_meas_t x, input logic [1:0] md);
        code = exp_code(md, x);
        i_wlsm_weld_src.send(x);
        #1;
        apb(1'b0, OFF_LAST_CODE, 32'h0);
        `CHK("last_code", {16'h0, code}, rd)
    endtask : weld

    // acknowledge halt and clear sticky events
    task automatic ack();
        apb(1'b1, OFF_ACK, 32'h1);
        apb(1'b1, OFF_IRQ_CLR, 32'h7);
        #1;
    endtask : ack

    task automatic run_chk(input logic [3:0] e);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("run_count", e, rd[7:4])
    endtask : run_chk

    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // watchdog against a hang
    initial begin
        #400000;
        failures++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'hbb2f));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        `CHK("go_held_start", 1'b0, cycle_go)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("wait_release", 1'b1, rd[STAT_WAIT_BIT])
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK("refuse_event", 3'b100, rd[2:0])
        apb(1'b0, OFF_CTRL, 32'h0);
        `CHK("ctrl_reset", CTRL_RST, rd)
        apb(1'b0, OFF_CUR_LIM, 32'h0);
        `CHK("cur_reset", {CUR_HI_RST, CUR_LO_RST}, rd)
        apb(1'b0, OFF_ANG_LIM, 32'h0);
        `CHK("ang_reset", {16'h0, ANG_HI_RST, ANG_LO_RST}, rd)
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_data", 32'h0, rd)
        op_start <= 1'b0;
        repeat (2) @(posedge pclk);
        op_start <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK("go_repressed", 1'b1, cycle_go)
        @(posedge pclk);
        op_start <= 1'b0;
        apb(1'b1, OFF_CUR_LIM, {ch, cl});
        apb(1'b1, OFF_ANG_LIM, {16'h0, ah, al});
        apb(1'b1, OFF_IRQ_EN, 32'h7);
        apb(1'b1, OFF_LAST_CODE, 32'hffff);
        apb(1'b0, OFF_LAST_CODE, 32'h0);
        `CHK("ro_write", 32'h0, rd)
        // every mode, threshold one, random and boundary measurements
        for (int md = 0; md < 4; md++) begin
            apb(1'b1, OFF_CTRL, {24'h0, 4'h1, 2'b00, md[1:0]});
            for (int i = 0; i < 12; i++) begin
                m.current = 16'($urandom_range(16'h2800, 16'h0800));
                m.angle = 8'($urandom);
                if (i == 0) m = '{cl, ah};
                if (i == 1) m = '{ch + 16'h1, al - 8'h1};
                weld(m, md[1:0]);
                `CHK("halt", code != CODE_NONE, halt)
                if (code != CODE_NONE) begin
                    `CHK("error_code", code, error_code)
                    `CHK("irq_on", 1'b1, irq)
                    op_start <= 1'b1;
                    @(posedge pclk);
                    #1;
                    `CHK("go_halted", 1'b0, cycle_go)
                    @(posedge pclk);
                    op_start <= 1'b0;
                    ack();
                    `CHK("halt_acked", 1'b0, halt)
                    `CHK("irq_off", 1'b0, irq)
                end
            end
        end
        // unbroken runs, threshold three
        apb(1'b1, OFF_CTRL, 32'h31);
        weld(bad, 2'h1);
        weld(bad, 2'h1);
        weld(good, 2'h1);
        run_chk(4'h0);
        weld(bad, 2'h1);
        weld(bad, 2'h1);
        `CHK("broken_run", 1'b0, halt)
        weld(bad, 2'h1);
        `CHK("run_halt", 1'b1, halt)
        i_wlsm_weld_src.send(good);
        #1;
        `CHK("frozen_code", CODE_LOW_CURRENT, error_code)
        ack();
        run_chk(4'h0);
        // threshold zero never halts; bad-weld event masked
        apb(1'b1, OFF_IRQ_EN, 32'h2);
        apb(1'b1, OFF_CTRL, 32'h01);
        for (int i = 0; i < 16; i++) weld(bad, 2'h1);
        `CHK("thr_zero", 1'b0, halt)
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK("irq_sticky", 3'b001, rd[2:0])
        run_chk(4'hf);
        ack();
        run_chk(4'h0);
        // threshold fifteen, combined mode, high angle
        apb(1'b1, OFF_CTRL, 32'hf3);
        m = '{16'h1800, 8'hc1};
        for (int i = 0; i < 14; i++) weld(m, 2'h3);
        `CHK("thr_15_early", 1'b0, halt)
        weld(m, 2'h3);
        `CHK("thr_15_halt", 1'b1, halt)
        `CHK("angle_code", CODE_HIGH_ANGLE, error_code)
        `CHK("irq_halt", 1'b1, irq)
        ack();
        wrap_up();
    end
endmodule : weld_limit_stop_monitor_tb

`default_nettype wire
